// file: sbcr_checker.sv
// Link assertions for the serial boot responder
`timescale 1ns/1ps
`default_nettype none
module sbcr_checker (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic c2d_valid,
    input wire logic [7:0] c2d_data,
    input wire logic c2d_err,
    input wire logic c2d_ready,
    input wire logic d2c_valid,
    input wire logic [7:0] d2c_data,
    input wire logic d2c_ready
);
    logic seen_ff, uart_ff, wait_ff;
    logic [7:0] last_ff;
    wire acc = d2c_valid & d2c_ready;
    wire tk = c2d_valid & c2d_ready;
    wire ok = tk & wait_ff & !(c2d_err & uart_ff);
    wire vc = c2d_data inside {8'h10, 8'h20, 8'h30, 8'h40};
    // Tracks command wait from the answers seen, not from device state
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            {seen_ff, uart_ff, wait_ff, last_ff} <= '0;
        end else begin
            if (acc) begin
                last_ff <= d2c_data;
                seen_ff <= 1'b1;
                uart_ff <= seen_ff ? uart_ff : d2c_data == 8'h86;
            end
            wait_ff <= acc ? d2c_data inside {8'h86, 8'h30, 8'h4f, 8'h4c} : wait_ff & !tk;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    stall_hold_a: assert property (d2c_valid & !d2c_ready
        |=> d2c_valid & $stable(d2c_data))
        else $error("stalled byte changed");
    rst_quiet_a: assert property (disable iff (1'b0) sys_rst_i
        |=> !d2c_valid & !c2d_ready)
        else $error("link busy after reset");
    mode_ack_a: assert property (d2c_valid & !seen_ff |-> d2c_data inside {8'h86, 8'h30})
        else $error("bad mode answer");
    cmd_echo_a: assert property (ok & vc
        |-> ##2 d2c_valid & d2c_data == $past(c2d_data, 2))
        else $error("command not echoed");
    bad_cmd_a: assert property (ok & !vc |-> ##2 d2c_valid & d2c_data[3:0] == 4'h1)
        else $error("bad command answer");
    rx_err_a: assert property (tk & wait_ff & c2d_err & uart_ff
        |-> ##2 d2c_data[3:0] == 4'h8)
        else $error("receive error answer");
    erase_en_a: assert property (tk & !c2d_err & last_ff == 8'h40 & c2d_data == 8'h54
        |-> ##2 d2c_valid & d2c_data == 8'h54)
        else $error("erase enable answer");
    erase_res_a: assert property (d2c_valid & last_ff == 8'h54
        |-> d2c_data inside {8'h4f, 8'h4c})
        else $error("erase result code");
    cover property (ok & c2d_data == 8'h20);
    cover property (d2c_valid & d2c_data == 8'h4c);
    cover property (acc & !seen_ff & d2c_data == 8'h30);
endmodule
`default_nettype wire

// file: sbcr_controller.sv
// Controller end: mode byte, echo check and byte passthrough
`timescale 1ns/1ps
`default_nettype none
module sbcr_controller #(
    parameter int BIT_CYC = sbcr_pkg::BIT_CYC_DEF,
    parameter int TMO_CYC = sbcr_pkg::ECHO_TMO_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Link to target
    sbcr_link_if.ctl lnk,
    // Session control
    input wire logic start_i,
    input wire logic io_mode_i,
    output logic link_up_o,
    output logic fail_o,
    // Bytes to target
    input wire logic usr_valid_i,
    input wire logic [7:0] usr_data_i,
    input wire logic usr_err_i,
    output logic usr_ready_o,
    // Bytes from target
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    input wire logic rsp_ready_i,
    // Checksum of bytes sent
    input wire logic sum_clr_i,
    output logic [7:0] chk_o
);
    import sbcr_pkg::*;

    localparam logic [15:0] PER_U = 16'(BIT_CYC - 1);
    localparam logic [15:0] PER_I = 16'(BIT_CYC * 16 - 1);
    sbcr_cstate_type state_ff;
    logic [9:0] frame_ff;
    logic [3:0] bit_ff;
    logic [15:0] tick_ff;
    logic [23:0] tmo_ff;
    logic [7:0] expect_ff, rsp_data_ff, sum_ff;
    logic io_ff, rsp_valid_ff, c2d_take, d2c_take;

    // ************************************************************
    // Session sequencer
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= C_IDLE;
            frame_ff <= '1;
            bit_ff <= '0;
            tick_ff <= '0;
            tmo_ff <= '0;
            expect_ff <= '0;
            io_ff <= 1'b0;
        end else begin
            case (state_ff)
                C_IDLE, C_FAIL: if (start_i) begin
                    // Clocked mode byte is sent slow so edge timing stays coarse-safe
                    expect_ff <= io_mode_i ? ACK_IO : ACK_UART;
                    frame_ff <= {1'b1, io_mode_i ? ACK_IO : ACK_UART, 1'b0};
                    io_ff <= io_mode_i;
                    bit_ff <= '0;
                    tick_ff <= '0;
                    state_ff <= C_SHIFT;
                end
                C_SHIFT: begin
                    if (tick_ff == (io_ff ? PER_I : PER_U)) begin
                        tick_ff <= '0;
                        frame_ff <= {1'b1, frame_ff[9:1]};
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == 4'h9) begin
                            tmo_ff <= '0;
                            state_ff <= C_WAIT;
                        end
                    end else begin
                        tick_ff <= tick_ff + 16'h0001;
                    end
                end
                C_WAIT: begin
                    tmo_ff <= tmo_ff + 24'h000001;
                    if (d2c_take) begin
                        state_ff <= (lnk.d2c_data == expect_ff) ? C_UP : C_FAIL;
                    end else if (tmo_ff == 24'(TMO_CYC - 1)) begin
                        state_ff <= C_FAIL;
                    end
                end
                C_UP: state_ff <= C_UP;
                default: state_ff <= C_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Byte paths
    // ************************************************************
    assign lnk.mode_line = (state_ff == C_SHIFT) ? frame_ff[0] : 1'b1;
    assign lnk.c2d_valid = state_ff == C_UP && usr_valid_i;
    assign lnk.c2d_data = usr_data_i;
    assign lnk.c2d_err = usr_err_i;
    assign usr_ready_o = state_ff == C_UP && lnk.c2d_ready;
    assign lnk.d2c_ready = state_ff == C_WAIT ||
                           (state_ff == C_UP && (!rsp_valid_ff || rsp_ready_i));
    assign c2d_take = lnk.c2d_valid && lnk.c2d_ready;
    assign d2c_take = lnk.d2c_valid && lnk.d2c_ready;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else if (state_ff == C_UP && d2c_take) begin
            rsp_valid_ff <= 1'b1;
            rsp_data_ff <= lnk.d2c_data;
        end else if (rsp_ready_i) begin
            rsp_valid_ff <= 1'b0;
        end
    end

    // A byte sent in the clearing cycle starts the new sum
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sum_ff <= '0;
        end else if (sum_clr_i) begin
            sum_ff <= c2d_take ? usr_data_i : 8'h00;
        end else if (c2d_take) begin
            sum_ff <= sum_ff + usr_data_i;
        end
    end

    assign chk_o = 8'h00 - sum_ff;
    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_data_o = rsp_data_ff;
    assign link_up_o = state_ff == C_UP;
    assign fail_o = state_ff == C_FAIL;
endmodule
`default_nettype wire

// file: sbcr_device.sv
// Target end: mode detection, command acks, password, flash sum, erase
`timescale 1ns/1ps
`default_nettype none
module sbcr_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff;
    logic [AW:0] cnt_ff;
    logic push, pop;

    assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o = mem_ff[rd_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

module sbcr_device #(
    parameter int FLASH_BYTES = sbcr_pkg::FLASH_BYTES_DEF,
    parameter int IDLE_CYC = sbcr_pkg::DET_IDLE_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Link to controller
    sbcr_link_if.dev lnk,
    // Flash read port, data one cycle after strobe
    output logic fl_rd_o,
    output logic [sbcr_pkg::FL_AW-1:0] fl_addr_o,
    input wire logic [7:0] fl_data_i,
    // Erase engine
    output logic erase_req_o,
    input wire logic erase_done_i,
    input wire logic erase_fail_i,
    // Status
    output logic mode_ok_o,
    output logic uart_mode_o
);
    import sbcr_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    sbcr_dstate_type state_ff, ret_ff, cmd_next;
    logic [TMR_W-1:0] timer_ff, t_a_ff, t_c_ff, first_edge_interval_ff;
    logic [TMR_W-1:0] third_edge_interval_ff, idle_ff;
    logic [2:0] edges_ff;
    logic line_ff, uart_ff, mode_ok_ff, err_seen_ff, mism_ff, pend_ff;
    logic [7:0] send_ff, csum_ff, rx_d;
    logic [3:0] hi_ff, idx_ff;
    logic [15:0] sum_ff, sum_add;
    logic [FL_AW-1:0] addr_ff;
    logic [7:0] pw_mem [PW_LEN];
    logic [PW_LEN-1:0] same_vec;
    logic line_edge, rx_take, rx_err, rx_ready, tx_ready, pw_area_err, is_uart;
    logic is_cmd, scan_cap, pw_rx_take;

    // ************************************************************
    // First byte timing
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            timer_ff <= '0;
            line_ff <= 1'b1;
        end else begin
            timer_ff <= timer_ff + 1'b1;
            line_ff <= lnk.mode_line;
        end
    end
    assign line_edge = line_ff != lnk.mode_line;

    // Wrap of the free timer is harmless: differences stay modular
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            edges_ff <= '0;
            t_a_ff <= '0;
            t_c_ff <= '0;
            first_edge_interval_ff <= '0;
            third_edge_interval_ff <= '0;
        end else if (state_ff == S_DET && line_edge) begin
            edges_ff <= edges_ff + 3'h1;
            case (edges_ff)
                3'h0: t_a_ff <= timer_ff;
                3'h1: first_edge_interval_ff <= timer_ff - t_a_ff;
                3'h2: t_c_ff <= timer_ff;
                default: third_edge_interval_ff <= timer_ff - t_c_ff;
            endcase
        end
    end

    // Wait for the rest of the mode byte to pass before replying
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || state_ff != S_SETTLE || line_edge || !lnk.mode_line) begin
            idle_ff <= '0;
        end else begin
            idle_ff <= idle_ff + 1'b1;
        end
    end
    assign is_uart = first_edge_interval_ff <= third_edge_interval_ff;

    // ************************************************************
    // Byte handshakes
    // ************************************************************
    assign rx_ready = (state_ff == S_CMD) || (state_ff == S_ERA_EN) ||
                      (state_ff == S_PW_RX) || (state_ff == S_PW_CK);
    assign lnk.c2d_ready = rx_ready;
    assign rx_take = lnk.c2d_valid && rx_ready;
    assign rx_err = lnk.c2d_err && uart_ff;
    assign rx_d = lnk.c2d_data;
    assign pw_rx_take = rx_take && state_ff == S_PW_RX;

    always_comb begin
        is_cmd = 1'b1;
        cmd_next = S_CMD;
        case (rx_d)
            CMD_RAM: cmd_next = S_PW_SCAN;
            CMD_SUM: cmd_next = S_SUM_RUN;
            CMD_INFO: cmd_next = S_CMD;
            CMD_ERASE: cmd_next = S_ERA_EN;
            default: is_cmd = 1'b0;
        endcase
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= S_DET;
            ret_ff <= S_DET;
            send_ff <= '0;
            hi_ff <= '0;
            uart_ff <= 1'b0;
            mode_ok_ff <= 1'b0;
        end else begin
            case (state_ff)
                S_DET: if (edges_ff == 3'h4) begin
                    state_ff <= S_SETTLE;
                end
                S_SETTLE: if (idle_ff == TMR_W'(IDLE_CYC)) begin
                    uart_ff <= is_uart;
                    if (is_uart && (first_edge_interval_ff < UART_AB_MIN ||
                                    first_edge_interval_ff > UART_AB_MAX)) begin
                        state_ff <= S_DEAD;
                    end else begin
                        mode_ok_ff <= 1'b1;
                        send_ff <= is_uart ? ACK_UART : ACK_IO;
                        ret_ff <= S_CMD;
                        state_ff <= S_SEND;
                    end
                end
                S_SEND: if (tx_ready) begin
                    state_ff <= ret_ff;
                end
                S_CMD: if (rx_take) begin
                    state_ff <= S_SEND;
                    ret_ff <= S_CMD;
                    if (rx_err) begin
                        send_ff <= {hi_ff, ACK_RXERR};
                    end else if (is_cmd) begin
                        hi_ff <= rx_d[7:4];
                        send_ff <= rx_d;
                        ret_ff <= cmd_next;
                    end else begin
                        send_ff <= {hi_ff, ACK_BAD};
                    end
                end
                S_ERA_EN: if (rx_take) begin
                    state_ff <= S_SEND;
                    ret_ff <= S_CMD;
                    if (rx_err) begin
                        send_ff <= {hi_ff, ACK_RXERR};
                    end else if (rx_d == ERASE_EN) begin
                        send_ff <= ERASE_EN;
                        ret_ff <= S_ERA_RUN;
                    end else begin
                        send_ff <= {hi_ff, ACK_BAD};
                    end
                end
                S_ERA_RUN: if (erase_done_i) begin
                    send_ff <= erase_fail_i ? ERASE_NG : ERASE_OK;
                    ret_ff <= S_CMD;
                    state_ff <= S_SEND;
                end
                S_PW_SCAN: if (scan_cap && idx_ff == 4'(PW_LEN-1)) begin
                    state_ff <= S_PW_RX;
                end
                S_PW_RX: if (rx_take && idx_ff == 4'(PW_LEN-1)) begin
                    state_ff <= S_PW_CK;
                end
                S_PW_CK: if (rx_take) begin
                    state_ff <= S_SEND;
                    ret_ff <= S_CMD;
                    if (rx_err || err_seen_ff) begin
                        send_ff <= {hi_ff, ACK_RXERR};
                    end else if (pw_area_err || mism_ff || (csum_ff + rx_d) != 8'h00) begin
                        send_ff <= {CMD_RAM[7:4], ACK_BAD};
                    end else begin
                        send_ff <= {hi_ff, ACK_GOOD};
                    end
                end
                S_SUM_RUN: if (pend_ff && addr_ff == FL_AW'(FLASH_BYTES-1)) begin
                    send_ff <= sum_add[15:8];
                    ret_ff <= S_SUM_LO;
                    state_ff <= S_SEND;
                end
                S_SUM_LO: begin
                    send_ff <= sum_ff[7:0];
                    ret_ff <= S_SUM_CK;
                    state_ff <= S_SEND;
                end
                S_SUM_CK: begin
                    send_ff <= 8'h00 - (sum_ff[15:8] + sum_ff[7:0]);
                    ret_ff <= S_CMD;
                    state_ff <= S_SEND;
                end
                S_DEAD: state_ff <= S_DEAD;
                default: state_ff <= S_DET;
            endcase
        end
    end

    // ************************************************************
    // Flash reads, password and sum datapath
    // ************************************************************
    // One read in flight at a time: half rate, but no return queue
    assign fl_rd_o = !pend_ff && (state_ff == S_PW_SCAN || state_ff == S_SUM_RUN);
    assign fl_addr_o = addr_ff;
    assign scan_cap = pend_ff && state_ff == S_PW_SCAN;
    assign sum_add = sum_ff + {8'h00, fl_data_i};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pend_ff <= 1'b0;
            idx_ff <= '0;
            addr_ff <= '0;
            sum_ff <= '0;
            csum_ff <= '0;
            mism_ff <= 1'b0;
            err_seen_ff <= 1'b0;
        end else begin
            pend_ff <= fl_rd_o;
            if (state_ff == S_CMD && rx_take) begin
                idx_ff <= '0;
                addr_ff <= (rx_d == CMD_RAM) ? PW_OFFSET : '0;
                sum_ff <= '0;
                csum_ff <= '0;
                mism_ff <= 1'b0;
                err_seen_ff <= 1'b0;
            end else if (pend_ff) begin
                addr_ff <= addr_ff + 1'b1;
            end
            if (scan_cap || pw_rx_take) begin
                idx_ff <= (idx_ff == 4'(PW_LEN-1)) ? '0 : idx_ff + 4'h1;
            end
            if (pw_rx_take) begin
                csum_ff <= csum_ff + rx_d;
                mism_ff <= mism_ff || (rx_d != pw_mem[idx_ff]);
                err_seen_ff <= err_seen_ff || rx_err;
            end
            if (pend_ff && state_ff == S_SUM_RUN) begin
                sum_ff <= sum_add;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (scan_cap) begin
            pw_mem[idx_ff] <= fl_data_i;
        end
    end

    for (genvar i = 0; i < PW_LEN; i++) begin : g_same
        assign same_vec[i] = pw_mem[i] == pw_mem[0];
    end
    assign pw_area_err = (&same_vec) && pw_mem[0] != ERASED;

    // ************************************************************
    // Outputs and answer buffer
    // ************************************************************
    assign erase_req_o = state_ff == S_ERA_RUN;
    assign mode_ok_o = mode_ok_ff;
    assign uart_mode_o = uart_ff;

    sbcr_buf #(.W(8), .DEPTH(2)) u_txbuf (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(state_ff == S_SEND),
        .in_data_i(send_ff),
        .in_ready_o(tx_ready),
        .out_valid_o(lnk.d2c_valid),
        .out_data_o(lnk.d2c_data),
        .out_ready_i(lnk.d2c_ready)
    );
endmodule
`default_nettype wire

// file: sbcr_link_if.sv
// Link between the boot controller and the target responder
`timescale 1ns/1ps
`default_nettype none
interface sbcr_link_if;
    logic mode_line;
    logic c2d_valid;
    logic [7:0] c2d_data;
    logic c2d_err;
    logic c2d_ready;
    logic d2c_valid;
    logic [7:0] d2c_data;
    logic d2c_ready;
    modport dev (
        input mode_line, c2d_valid, c2d_data, c2d_err, d2c_ready,
        output c2d_ready, d2c_valid, d2c_data
    );
    modport ctl (
        output mode_line, c2d_valid, c2d_data, c2d_err, d2c_ready,
        input c2d_ready, d2c_valid, d2c_data
    );
endinterface
`default_nettype wire

// file: sbcr_pkg.sv
// Constants and types shared by both ends of the serial boot link
package sbcr_pkg;
    // ************************************************************
    // Protocol codes
    // ************************************************************
    localparam logic [7:0] ACK_UART = 8'h86;
    localparam logic [7:0] ACK_IO = 8'h30;
    localparam logic [7:0] CMD_RAM = 8'h10;
    localparam logic [7:0] CMD_SUM = 8'h20;
    localparam logic [7:0] CMD_INFO = 8'h30;
    localparam logic [7:0] CMD_ERASE = 8'h40;
    localparam logic [7:0] ERASE_EN = 8'h54;
    localparam logic [7:0] ERASE_OK = 8'h4f;
    localparam logic [7:0] ERASE_NG = 8'h4c;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [3:0] ACK_RXERR = 4'h8;
    localparam logic [3:0] ACK_BAD = 4'h1;
    localparam logic [3:0] ACK_GOOD = 4'h0;
    // ************************************************************
    // Flash layout
    // ************************************************************
    localparam int FL_AW = 19;
    localparam int FLASH_BYTES_DEF = 524288;
    localparam logic [FL_AW-1:0] PW_OFFSET = 19'h1ff04;
    localparam int PW_LEN = 12;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int TMR_W = 20;
    localparam int CLK_MHZ = 200;
    localparam int BIT_NS = 1000;
    localparam int BIT_CYC_DEF = BIT_NS * CLK_MHZ / 1000;
    localparam int DET_IDLE_NS = 20000;
    localparam int DET_IDLE_CYC = DET_IDLE_NS * CLK_MHZ / 1000;
    localparam int ECHO_TMO_US = 50;
    localparam int ECHO_TMO_CYC = ECHO_TMO_US * CLK_MHZ;
    localparam logic [TMR_W-1:0] UART_AB_MIN = 20'h00010;
    localparam logic [TMR_W-1:0] UART_AB_MAX = 20'h0ea60;
    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [3:0] {
        S_DET = 4'h0, S_SETTLE = 4'h1, S_DEAD = 4'h2, S_SEND = 4'h3,
        S_CMD = 4'h4, S_ERA_EN = 4'h5, S_ERA_RUN = 4'h6, S_PW_SCAN = 4'h7,
        S_PW_RX = 4'h8, S_PW_CK = 4'h9, S_SUM_RUN = 4'ha, S_SUM_LO = 4'hb,
        S_SUM_CK = 4'hc
    } sbcr_dstate_type;
    typedef enum logic [2:0] {
        C_IDLE = 3'h0, C_SHIFT = 3'h1, C_WAIT = 3'h2, C_UP = 3'h3, C_FAIL = 3'h4
    } sbcr_cstate_type;
endpackage

// file: sbcr_tb.sv
// Bench for both ends of the serial boot link
`timescale 1ns/1ps
`default_nettype none
module sbcr_tb;
    import sbcr_pkg::*;
    localparam int FB = 8;
    logic core_clk_i, sys_rst_i, start_i, io_mode_i, usr_valid_i, usr_err_i, rsp_ready_i;
    logic sum_clr_i, fl_rd_o, erase_req_o, erase_done_i, erase_fail_i, mode_ok_o, flat;
    logic uart_mode_o, link_up_o, fail_o, usr_ready_o, rsp_valid_o;
    logic [7:0] usr_data_i, rsp_data_o, chk_o, fl_data_i;
    logic [FL_AW-1:0] fl_addr_o;
    int n_errors, samples_checked;
    sbcr_link_if lnk ();
    sbcr_device #(.FLASH_BYTES(FB), .IDLE_CYC(250)) i_sbcr_device (.core_clk_i, .sys_rst_i,
        .lnk(lnk), .fl_rd_o, .fl_addr_o, .fl_data_i, .erase_req_o, .erase_done_i,
        .erase_fail_i, .mode_ok_o, .uart_mode_o);
    sbcr_controller #(.BIT_CYC(10), .TMO_CYC(8000)) i_sbcr_controller (.core_clk_i,
        .sys_rst_i, .lnk(lnk), .start_i, .io_mode_i, .link_up_o, .fail_o, .usr_valid_i,
        .usr_data_i, .usr_err_i, .usr_ready_o, .rsp_valid_o, .rsp_data_o, .rsp_ready_i,
        .sum_clr_i, .chk_o);
    sbcr_checker i_sbcr_checker (.core_clk_i, .sys_rst_i, .c2d_valid(lnk.c2d_valid),
        .c2d_data(lnk.c2d_data), .c2d_err(lnk.c2d_err), .c2d_ready(lnk.c2d_ready),
        .d2c_valid(lnk.d2c_valid), .d2c_data(lnk.d2c_data), .d2c_ready(lnk.d2c_ready));
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    // Flash answers one cycle late; erase finishes one cycle after request
    always @(posedge core_clk_i) begin
        fl_data_i <= #1 (flat && fl_addr_o >= PW_OFFSET) ? 8'h77 : fl_addr_o[7:0] + 8'h31;
        erase_done_i <= #1 erase_req_o & !erase_done_i;
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(logic [7:0] d, logic e = 1'b0);
        usr_data_i = d;
        usr_err_i = e;
        usr_valid_i = 1'b1;
        do @(posedge core_clk_i); while (!usr_ready_o);
        #1 usr_valid_i = 1'b0;
        // Idle edge so back-to-back puts never rewrite valid in one step
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic get(logic [7:0] exp);
        do @(posedge core_clk_i); while (!(rsp_valid_o && rsp_ready_i));
        chk("answer", exp, rsp_data_o);
        #1;
    endtask
    task automatic t_link(logic io);
        sys_rst_i = 1'b1;
        repeat (16) @(posedge core_clk_i);
        #1 sys_rst_i = 1'b0;
        io_mode_i = io;
        start_i = 1'b1;
        @(posedge core_clk_i);
        #1 start_i = 1'b0;
        repeat (4000) if (link_up_o !== 1'b1) @(posedge core_clk_i);
        chk("link up", 8'h1, {7'h0, link_up_o});
        chk("uart flag", {7'h0, !io}, {7'h0, uart_mode_o});
        chk("mode ok", 8'h1, {7'h0, mode_ok_o});
        chk("fail", 8'h0, {7'h0, fail_o});
        #1;
    endtask
    task automatic t_sum();
        logic [15:0] s = '0;
        for (int i = 0; i < FB; i++) s += 16'(i) + 16'h31;
        put(CMD_SUM);
        get(CMD_SUM);
        rsp_ready_i = 1'b0;
        repeat (60) @(posedge core_clk_i);
        #1 rsp_ready_i = 1'b1;
        get(s[15:8]);
        get(s[7:0]);
        get(8'h0 - s[15:8] - s[7:0]);
    endtask
    task automatic t_ram(logic f, logic bad, logic [7:0] exp, logic e = 1'b0);
        logic [7:0] c = '0;
        logic [7:0] b;
        flat = f;
        put(CMD_RAM);
        get(CMD_RAM);
        sum_clr_i = 1'b1;
        @(posedge core_clk_i);
        #1 sum_clr_i = 1'b0;
        for (int i = 4; i < 16; i++) begin
            b = f ? 8'h77 : 8'(i) + 8'h31 + {7'h0, bad && i == 9};
            put(b, e && i == 6);
            c -= b;
        end
        chk("checksum", c, chk_o);
        put(chk_o);
        get(exp);
    endtask
    task automatic t_erase(logic f, logic [7:0] exp);
        erase_fail_i = f;
        put(CMD_ERASE);
        get(CMD_ERASE);
        put(ERASE_EN);
        get(ERASE_EN);
        get(exp);
        put(CMD_INFO);
        get(CMD_INFO);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Whole run is a few thousand cycles; this leaves wide margin
    initial begin
        #200us;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {start_i, io_mode_i, usr_valid_i, usr_err_i, sum_clr_i, erase_fail_i, flat} = '0;
        {usr_data_i, fl_data_i, erase_done_i} = '0;
        rsp_ready_i = 1'b1;
        t_link(1'b0);
        put(8'h30);
        get(8'h30);
        put(8'h75);
        get(8'h31);
        put(8'h30);
        get(8'h30);
        put(8'h20, 1'b1);
        get(8'h38);
        $display("command test done");
        t_sum();
        $display("sum test done");
        t_ram(1'b0, 1'b0, 8'h10);
        t_ram(1'b0, 1'b1, 8'h11);
        t_ram(1'b1, 1'b0, 8'h11);
        t_ram(1'b0, 1'b0, 8'h18, 1'b1);
        $display("password test done");
        t_erase(1'b0, ERASE_OK);
        t_erase(1'b1, ERASE_NG);
        put(CMD_ERASE);
        get(CMD_ERASE);
        put(8'h55);
        get(8'h41);
        $display("erase test done");
        t_link(1'b1);
        put(CMD_INFO, 1'b1);
        get(CMD_INFO);
        $display("clocked mode test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
